// File: inc/sce_pkg.sv
// Constants and types for the socket command and event flag block.
// Assumes a single system clock and an attached network engine on the same clock.
package sce_pkg;

	// Register offsets.
	localparam logic [7:0] OFS_MODE      = 8'h00;
	localparam logic [7:0] OFS_CMD       = 8'h01;
	localparam logic [7:0] OFS_FLAGS     = 8'h02;
	localparam logic [7:0] OFS_STATE     = 8'h03;
	localparam logic [7:0] OFS_HWADDR_LO = 8'h06;
	localparam logic [7:0] OFS_HWADDR_HI = 8'h0B;
	localparam logic [7:0] OFS_TXRD_H    = 8'h22;
	localparam logic [7:0] OFS_TXRD_L    = 8'h23;
	localparam logic [7:0] OFS_TXWR_H    = 8'h24;
	localparam logic [7:0] OFS_TXWR_L    = 8'h25;
	localparam logic [7:0] OFS_RXRD_H    = 8'h28;
	localparam logic [7:0] OFS_RXRD_L    = 8'h29;
	localparam logic [7:0] OFS_MASK      = 8'h2C;

	// Reset values.
	localparam logic [7:0]  RST_MODE   = 8'h00;
	localparam logic [7:0]  RST_FLAGS  = 8'h00;
	localparam logic [7:0]  RST_MASK   = 8'hFF;
	localparam logic [47:0] RST_HWADDR = 48'hFFFF_FFFF_FFFF;
	localparam logic [15:0] RST_PTR    = 16'h0000;

	// Protocol field of the mode register.
	localparam logic [3:0] PROTO_TCP = 4'h1;
	localparam logic [3:0] PROTO_UDP = 4'h2;

	// Command codes.
	localparam logic [7:0] CMD_NONE      = 8'h00;
	localparam logic [7:0] CMD_GRACEFUL_DISCONNECT_CMD    = 8'h08;
	localparam logic [7:0] CMD_CLOSE     = 8'h10;
	localparam logic [7:0] CMD_SEND      = 8'h20;
	localparam logic [7:0] CMD_SEND_NOAR = 8'h21;
	localparam logic [7:0] CMD_KEEPALIVE = 8'h22;
	localparam logic [7:0] CMD_RECEIVE_COMPLETE_CMD_DONE = 8'h40;

	// Socket state codes.
	localparam logic [7:0] ST_RELEASED   = 8'h00;
	localparam logic [7:0] ST_CONNECTED  = 8'h17;
	localparam logic [7:0] ST_FIN_WAIT   = 8'h18;
	localparam logic [7:0] ST_CLOSE_WAIT = 8'h1C;
	localparam logic [7:0] ST_LAST_ACK   = 8'h1D;

	// Event flag bit positions.
	localparam int FLAG_CONNECTED  = 0;
	localparam int FLAG_PEER_DISC  = 1;
	localparam int FLAG_RECEIVE    = 2;
	localparam int FLAG_TIMEOUT    = 3;
	localparam int FLAG_TX_DONE    = 4;
	localparam int FLAG_COUNT      = 5;

	// Length of a keep-alive probe in bytes.
	localparam logic [15:0] KEEPALIVE_LEN = 16'h0001;

	// Events reported by the network engine, one-cycle pulses.
	typedef struct packed {
		logic connectOk;
		logic finRcvd;
		logic finAckRcvd;
		logic rstRcvd;
		logic dataRcvd;
		logic arpDone;
		logic arpTimeout;
		logic tcpTimeout;
		logic sendDone;
		logic keepAck;
	} sce_net_evt_t;

	// Requests to the network engine; the strobes are one-cycle pulses.
	typedef struct packed {
		logic        finReq;
		logic        arpReq;
		logic        sendReq;
		logic        skipResolve;
		logic        keepReq;
		logic        rxRelease;
		logic [15:0] sendFrom;
		logic [15:0] sendTo;
		logic [15:0] rxReadPtr;
		logic [47:0] peerHwAddr;
	} sce_net_req_t;

	// Operation in progress.
	typedef enum logic [2:0] {
		OP_IDLE,
		OP_ARP,
		OP_SEND,
		OP_TEARDOWN,
		OP_KEEP
	} sce_op_t;

endpackage

// File: verilog/sce_event_flags.sv
// Write-one-to-clear event flags gated by a mask.
// Assumes events and clear strobes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sce_event_flags #(
	parameter int FLAGS = 5
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [FLAGS-1:0] eventIn,
	input  wire logic [FLAGS-1:0] mask,
	input  wire logic             clearWrite,
	input  wire logic [FLAGS-1:0] clearBits,
	output var  logic [FLAGS-1:0] flags
);
	if (FLAGS < 1 || FLAGS > 8) begin : g_bad
		$error("FLAGS must lie between 1 and 8.");
	end

	for (genvar i = 0; i < FLAGS; i++) begin : g_flag
		// Set wins over a clear in the same cycle.
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				flags[i] <= 1'b0;
			end else if (eventIn[i] && mask[i]) begin
				flags[i] <= 1'b1;
			end else if (clearWrite && clearBits[i]) begin
				flags[i] <= 1'b0;
			end
		end

		chk_flag_masked_set: assert property (@(posedge clk) disable iff (reset)
			(eventIn[i] && mask[i]) |=> flags[i])
			else $error("Unmasked event did not set its flag.");
		chk_flag_wone_clear: assert property (@(posedge clk) disable iff (reset)
			(clearWrite && clearBits[i] && !(eventIn[i] && mask[i])) |=> !flags[i])
			else $error("Write of one did not clear the flag.");
		chk_flag_no_spurious: assert property (@(posedge clk) disable iff (reset)
			(!flags[i] && !(eventIn[i] && mask[i])) |=> !flags[i])
			else $error("Flag rose without an unmasked event.");
	end
endmodule // sce_event_flags
`default_nettype wire

// File: verilog/sce_hw_addr_store.sv
// Byte-writable store for the destination hardware address.
// Assumes byte writes arrive from the register port on the same clock.
`timescale 1ns/100ps
`default_nettype none
module sce_hw_addr_store #(
	parameter int BYTES = 6
) (
	input  wire logic               clk,
	input  wire logic               reset,
	input  wire logic [BYTES-1:0]   byteWrite,
	input  wire logic [7:0]         wdata,
	output var  logic [BYTES*8-1:0] hwAddr
);
	import sce_pkg::*;

	if (BYTES != 6) begin : g_bad
		$error("BYTES must be 6.");
	end

	// Byte 0 is the first on the wire and sits in the top bits.
	for (genvar i = 0; i < BYTES; i++) begin : g_byte
		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				hwAddr[(BYTES-1-i)*8 +: 8] <= RST_HWADDR[(BYTES-1-i)*8 +: 8];
			end else if (byteWrite[i]) begin
				hwAddr[(BYTES-1-i)*8 +: 8] <= wdata;
			end
		end
	end
endmodule // sce_hw_addr_store
`default_nettype wire

// File: verilog/sce_socket_cmd.sv
// Socket command executor with socket state and event flags.
// Assumes a register port behind the serial host bus and a network engine on the same clock.
//
// What this block does
// - Graceful disconnect 0x08 runs teardown in TCP mode only, server or client.
// - Active teardown sends a FIN to the connected peer.
// - Passive teardown answers a received FIN with our own FIN.
// - Teardown success on FIN/ACK moves socket state to released.
// - Teardown failure by TCP timeout sets flag bit 3 and releases the socket.
// - Immediate close 0x10 releases the socket at once, no packet exchange.
// - A received RST releases the socket unconditionally.
// - Transmit 0x20 sends all buffered data between read and write pointers.
// - Normal transmit resolves the hardware address first.
// - Transmit 0x21 in UDP only skips resolution, uses host-set peer address.
// - Keep-alive 0x22 in TCP only sends a one-byte probe.
// - Unanswered keep-alive terminates the connection and raises the timeout flag.
// - Receive-complete 0x40 releases received data up to the host read pointer.
// - A flag sets on its event only while its mask bit is one.
// - Writing one to a flag bit clears exactly that bit.
// - Transmit completion sets flag bit 4.
// - Address resolution or TCP retry timeout sets flag bit 3.
// - Every data arrival sets flag bit 2.
// - A received FIN or FIN/ACK sets flag bit 1.
// - Entering the connected state sets flag bit 0 once.
// - Released state reads as 0x00 after disconnect, close or timeout.
// - Connected state reads as 0x17 after accepted SYN or successful connect.
`timescale 1ns/100ps
`default_nettype none
module sce_socket_cmd (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic [7:0]            regAddr,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	input  wire logic [7:0]            regWdata,
	output var  logic [7:0]            regRdata,
	output var  logic                  regRvalid,
	input  wire sce_pkg::sce_net_evt_t netEvent,
	input  wire logic [15:0]           txReadPtr,
	output var  sce_pkg::sce_net_req_t netReq
);
	import sce_pkg::*;

	logic [7:0]           modeReg;
	logic [7:0]           cmdReg;
	logic [7:0]           maskReg;
	logic [7:0]           socketState;
	logic [15:0]          txWritePtr;
	logic [15:0]          rxReadPtr;
	logic [47:0]          peerHwAddr;
	logic [FLAG_COUNT-1:0] flags;
	logic [FLAG_COUNT-1:0] flagEvents;
	logic [5:0]           hwByteWrite;
	sce_op_t              opState;
	logic                 isTcp;
	logic                 isUdp;
	logic                 cmdTake;
	logic                 closeTake;
	logic                 wrFlags;

	assign isTcp = (modeReg[3:0] == PROTO_TCP);
	assign isUdp = (modeReg[3:0] == PROTO_UDP);
	// Close is taken even while another command runs; others wait for idle.
	assign closeTake = (cmdReg == CMD_CLOSE);
	assign cmdTake   = (cmdReg != CMD_NONE) && (opState == OP_IDLE);
	assign wrFlags   = regWrite && (regAddr == OFS_FLAGS);

	// Host-written configuration registers.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			modeReg    <= RST_MODE;
			maskReg    <= RST_MASK;
			txWritePtr <= RST_PTR;
			rxReadPtr  <= RST_PTR;
		end else if (regWrite) begin
			unique case (regAddr)
				OFS_MODE:   modeReg           <= regWdata;
				OFS_MASK:   maskReg           <= regWdata;
				OFS_TXWR_H: txWritePtr[15:8]  <= regWdata;
				OFS_TXWR_L: txWritePtr[7:0]   <= regWdata;
				OFS_RXRD_H: rxReadPtr[15:8]   <= regWdata;
				OFS_RXRD_L: rxReadPtr[7:0]    <= regWdata;
				default: begin
				end
			endcase
		end
	end

	// Command register reads nonzero until the command is taken.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmdReg <= CMD_NONE;
		end else if (regWrite && regAddr == OFS_CMD) begin
			cmdReg <= regWdata;
		end else if (cmdTake || closeTake) begin
			cmdReg <= CMD_NONE;
		end
	end

	for (genvar i = 0; i < 6; i++) begin : g_hwsel
		assign hwByteWrite[i] = regWrite && (regAddr == OFS_HWADDR_LO + 8'(i));
	end

	sce_hw_addr_store #(
		.BYTES (6)
	) u_hw_addr (
		.clk       (clk),
		.reset     (reset),
		.byteWrite (hwByteWrite),
		.wdata     (regWdata),
		.hwAddr    (peerHwAddr)
	);

	// Operation sequencer.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			opState <= OP_IDLE;
		end else if (netEvent.rstRcvd || closeTake) begin
			opState <= OP_IDLE;
		end else begin
			unique case (opState)
				OP_IDLE: begin
					if (cmdTake) begin
						if (cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp) begin
							opState <= OP_TEARDOWN;
						end else if (cmdReg == CMD_SEND) begin
							opState <= OP_ARP;
						end else if (cmdReg == CMD_SEND_NOAR && isUdp) begin
							opState <= OP_SEND;
						end else if (cmdReg == CMD_KEEPALIVE && isTcp) begin
							opState <= OP_KEEP;
						end
					end
				end
				OP_ARP: begin
					if (netEvent.arpTimeout) begin
						opState <= OP_IDLE;
					end else if (netEvent.arpDone) begin
						opState <= OP_SEND;
					end
				end
				OP_SEND: begin
					if (netEvent.sendDone || netEvent.tcpTimeout) begin
						opState <= OP_IDLE;
					end
				end
				OP_TEARDOWN: begin
					if (netEvent.finAckRcvd || netEvent.tcpTimeout) begin
						opState <= OP_IDLE;
					end
				end
				OP_KEEP: begin
					if (netEvent.keepAck || netEvent.tcpTimeout) begin
						opState <= OP_IDLE;
					end
				end
			endcase
		end
	end

	// Socket state register.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			socketState <= ST_RELEASED;
		end else if (netEvent.rstRcvd || closeTake) begin
			socketState <= ST_RELEASED;
		end else if (netEvent.tcpTimeout) begin
			socketState <= ST_RELEASED;
		end else if (opState == OP_TEARDOWN && netEvent.finAckRcvd) begin
			socketState <= ST_RELEASED;
		end else if (cmdTake && cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp) begin
			if (socketState == ST_CLOSE_WAIT) begin
				socketState <= ST_LAST_ACK;
			end else begin
				socketState <= ST_FIN_WAIT;
			end
		end else if (netEvent.connectOk) begin
			socketState <= ST_CONNECTED;
		end else if (netEvent.finRcvd && socketState == ST_CONNECTED) begin
			socketState <= ST_CLOSE_WAIT;
		end
	end

	// Requests to the network engine.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			netReq <= '0;
		end else begin
			netReq.finReq      <= 1'b0;
			netReq.arpReq      <= 1'b0;
			netReq.sendReq     <= 1'b0;
			netReq.skipResolve <= 1'b0;
			netReq.keepReq     <= 1'b0;
			netReq.rxRelease   <= 1'b0;
			netReq.peerHwAddr  <= peerHwAddr;
			if (cmdTake && !closeTake && !netEvent.rstRcvd) begin
				if (cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp) begin
					netReq.finReq <= 1'b1;
				end else if (cmdReg == CMD_SEND) begin
					netReq.arpReq <= 1'b1;
				end else if (cmdReg == CMD_SEND_NOAR && isUdp) begin
					netReq.sendReq     <= 1'b1;
					netReq.skipResolve <= 1'b1;
					netReq.sendFrom    <= txReadPtr;
					netReq.sendTo      <= txWritePtr;
				end else if (cmdReg == CMD_KEEPALIVE && isTcp) begin
					netReq.keepReq  <= 1'b1;
					netReq.sendFrom <= txReadPtr;
					netReq.sendTo   <= txReadPtr + KEEPALIVE_LEN;
				end else if (cmdReg == CMD_RECEIVE_COMPLETE_CMD_DONE) begin
					netReq.rxRelease <= 1'b1;
					netReq.rxReadPtr <= rxReadPtr;
				end
			end else if (opState == OP_ARP && netEvent.arpDone && !netEvent.arpTimeout
				&& !closeTake && !netEvent.rstRcvd) begin
				netReq.sendReq  <= 1'b1;
				netReq.sendFrom <= txReadPtr;
				netReq.sendTo   <= txWritePtr;
			end
		end
	end

	// Event sources for the flag register.
	always_comb begin
		flagEvents                 = '0;
		flagEvents[FLAG_CONNECTED] = netEvent.connectOk && socketState != ST_CONNECTED;
		flagEvents[FLAG_PEER_DISC] = netEvent.finRcvd || netEvent.finAckRcvd;
		flagEvents[FLAG_RECEIVE]   = netEvent.dataRcvd;
		flagEvents[FLAG_TIMEOUT]   = netEvent.arpTimeout || netEvent.tcpTimeout;
		flagEvents[FLAG_TX_DONE]   = netEvent.sendDone && opState == OP_SEND;
	end

	sce_event_flags #(
		.FLAGS (FLAG_COUNT)
	) u_flags (
		.clk        (clk),
		.reset      (reset),
		.eventIn    (flagEvents),
		.mask       (maskReg[FLAG_COUNT-1:0]),
		.clearWrite (wrFlags),
		.clearBits  (regWdata[FLAG_COUNT-1:0]),
		.flags      (flags)
	);

	// Register read port; unmapped addresses read zero.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			regRdata  <= 8'h00;
			regRvalid <= 1'b0;
		end else begin
			regRvalid <= regRead;
			if (regRead) begin
				if (regAddr >= OFS_HWADDR_LO && regAddr <= OFS_HWADDR_HI) begin
					regRdata <= peerHwAddr[8'(8'd5 - (regAddr - OFS_HWADDR_LO)) * 8 +: 8];
				end else begin
					unique case (regAddr)
						OFS_MODE:   regRdata <= modeReg;
						OFS_CMD:    regRdata <= cmdReg;
						OFS_FLAGS:  regRdata <= {{(8 - FLAG_COUNT){1'b0}}, flags};
						OFS_STATE:  regRdata <= socketState;
						OFS_MASK:   regRdata <= maskReg;
						OFS_TXRD_H: regRdata <= txReadPtr[15:8];
						OFS_TXRD_L: regRdata <= txReadPtr[7:0];
						OFS_TXWR_H: regRdata <= txWritePtr[15:8];
						OFS_TXWR_L: regRdata <= txWritePtr[7:0];
						OFS_RXRD_H: regRdata <= rxReadPtr[15:8];
						OFS_RXRD_L: regRdata <= rxReadPtr[7:0];
						default:    regRdata <= 8'h00;
					endcase
				end
			end
		end
	end

	chk_graceful_disconnect_cmd_sends_fin: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp && !netEvent.rstRcvd)
		|=> netReq.finReq && opState == OP_TEARDOWN)
		else $error("Graceful disconnect did not send FIN.");
	chk_graceful_disconnect_cmd_tcp_only: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && !isTcp) |=> !netReq.finReq)
		else $error("Disconnect acted outside TCP mode.");
	chk_teardown_release: assert property (@(posedge clk) disable iff (reset)
		(opState == OP_TEARDOWN && netEvent.finAckRcvd) |=> socketState == ST_RELEASED)
		else $error("FIN/ACK did not release the socket.");
	chk_tcp_timeout: assert property (@(posedge clk) disable iff (reset)
		(netEvent.tcpTimeout && maskReg[FLAG_TIMEOUT])
		|=> socketState == ST_RELEASED && flags[FLAG_TIMEOUT])
		else $error("TCP timeout did not release and flag.");
	chk_close_release: assert property (@(posedge clk) disable iff (reset)
		closeTake |=> socketState == ST_RELEASED && !netReq.finReq && opState == OP_IDLE)
		else $error("Close did not release at once.");
	chk_rst_release: assert property (@(posedge clk) disable iff (reset)
		netEvent.rstRcvd |=> socketState == ST_RELEASED)
		else $error("RST did not release the socket.");
	chk_send_resolves: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_SEND && !closeTake && !netEvent.rstRcvd)
		|=> netReq.arpReq && !netReq.sendReq)
		else $error("Send skipped address resolution.");
	chk_noar_skips: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_SEND_NOAR && isUdp && !netEvent.rstRcvd)
		|=> netReq.sendReq && netReq.skipResolve && !netReq.arpReq
			&& netReq.peerHwAddr == $past(peerHwAddr))
		else $error("Send without resolution misbehaved.");
	chk_keep_one_byte: assert property (@(posedge clk) disable iff (reset)
		netReq.keepReq |-> netReq.sendTo == netReq.sendFrom + KEEPALIVE_LEN)
		else $error("Keep-alive probe is not one byte.");
	chk_receive_complete_cmd_pointer: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_RECEIVE_COMPLETE_CMD_DONE && !netEvent.rstRcvd)
		|=> netReq.rxRelease && netReq.rxReadPtr == $past(rxReadPtr))
		else $error("Receive-complete used a wrong pointer.");
	chk_connected_code: assert property (@(posedge clk) disable iff (reset)
		(netEvent.connectOk && !netEvent.rstRcvd && !closeTake && !netEvent.tcpTimeout
			&& !(cmdTake && cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp)
			&& !(opState == OP_TEARDOWN && netEvent.finAckRcvd))
		|=> socketState == ST_CONNECTED)
		else $error("Connect did not reach the connected state.");
	chk_txdone_flag: assert property (@(posedge clk) disable iff (reset)
		(opState == OP_SEND && netEvent.sendDone && maskReg[FLAG_TX_DONE])
		|=> flags[FLAG_TX_DONE] && opState == OP_IDLE)
		else $error("Transmit completion not flagged.");
	chk_passive_last_ack: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_GRACEFUL_DISCONNECT_CMD && isTcp && socketState == ST_CLOSE_WAIT
			&& !netEvent.rstRcvd && !netEvent.tcpTimeout)
		|=> socketState == ST_LAST_ACK && netReq.finReq)
		else $error("Passive teardown did not answer with FIN.");
	chk_noar_udp_only: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_SEND_NOAR && !isUdp) |=> !netReq.sendReq)
		else $error("Send without resolution acted outside UDP mode.");
	chk_keep_tcp_only: assert property (@(posedge clk) disable iff (reset)
		(cmdTake && cmdReg == CMD_KEEPALIVE && !isTcp) |=> !netReq.keepReq)
		else $error("Keep-alive acted outside TCP mode.");
	chk_keep_timeout: assert property (@(posedge clk) disable iff (reset)
		(opState == OP_KEEP && netEvent.tcpTimeout) |=> socketState == ST_RELEASED && opState == OP_IDLE)
		else $error("Unanswered keep-alive did not end the connection.");
	chk_connect_flag_once: assert property (@(posedge clk) disable iff (reset)
		(netEvent.connectOk && socketState == ST_CONNECTED && !flags[FLAG_CONNECTED]) |=> !flags[FLAG_CONNECTED])
		else $error("Connected flag set twice for one connection.");
	chk_arp_timeout_flag: assert property (@(posedge clk) disable iff (reset)
		(netEvent.arpTimeout && maskReg[FLAG_TIMEOUT]) |=> flags[FLAG_TIMEOUT])
		else $error("Resolution timeout not flagged.");
	chk_rx_flag: assert property (@(posedge clk) disable iff (reset)
		(netEvent.dataRcvd && maskReg[FLAG_RECEIVE]) |=> flags[FLAG_RECEIVE])
		else $error("Data arrival not flagged.");
	chk_disc_flag: assert property (@(posedge clk) disable iff (reset)
		((netEvent.finRcvd || netEvent.finAckRcvd) && maskReg[FLAG_PEER_DISC]) |=> flags[FLAG_PEER_DISC])
		else $error("Peer disconnect not flagged.");
endmodule // sce_socket_cmd
`default_nettype wire

// File: bench/sce_net_peer.sv
// Behavioural network engine and remote peer that answer the block's requests.
// Assumes requests arrive as one-cycle pulses on the rising edge of the shared clock.
`timescale 1ns/100ps
`default_nettype none
module sce_net_peer (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire sce_pkg::sce_net_req_t req,
	input  wire sce_pkg::sce_net_evt_t inject,
	input  wire logic [3:0]            delay,
	input  wire logic                  fail,
	output var  sce_pkg::sce_net_evt_t evt
);
	import sce_pkg::*;
	sce_net_evt_t resp = '0;

	// Answers one request after the chosen delay, or lets the retry timer expire.
	task automatic reply(input sce_net_req_t r);
		sce_net_evt_t e;
		e = '0;
		repeat (delay + 1) @(negedge clk);
		e.arpDone    = r.arpReq & ~fail;
		e.arpTimeout = r.arpReq & fail;
		e.sendDone   = r.sendReq;
		e.finAckRcvd = r.finReq & ~fail;
		e.keepAck    = r.keepReq & ~fail;
		e.tcpTimeout = (r.finReq | r.keepReq) & fail;
		resp = e;
		@(negedge clk);
		resp = '0;
	endtask

	always @(negedge clk) begin
		if (!reset && (req.arpReq || req.sendReq || req.finReq || req.keepReq)) begin
			fork
				reply(req);
			join_none
		end
	end

	assign evt = resp | inject;
endmodule // sce_net_peer
`default_nettype wire

// File: bench/sce_socket_cmd_tb.sv
// Self-checking bench for the socket command block with a reference model.
// Assumes the engine model drives events at falling edges of the same clock.
`timescale 1ns/100ps
`default_nettype none
module sce_socket_cmd_tb;
	import sce_pkg::*;
	logic         clk = 0, reset = 1, regWrite = 0, regRead = 0, fail = 0, regRvalid, lastSkip;
	logic [7:0]   regAddr = '0, regWdata = '0, regRdata;
	logic [3:0]   delay = '0;
	logic [9:0]   inject = '0;
	logic [15:0]  txReadPtr = '0, lastFrom, lastTo, lastRx;
	logic [31:0]  rnd = 32'd92628;
	logic [47:0]  lastHw;
	sce_net_evt_t netEvent;
	sce_net_req_t netReq;
	int nErrors = 0, nChecks = 0, cycles = 0, expState = 0, expFlags = 0, expMask = 255;
	int nArp = 0, nSend = 0, nFin = 0, nKeep = 0, nRel = 0, arpAtSend = 0;

	sce_socket_cmd dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
		.netEvent(netEvent), .txReadPtr(txReadPtr), .netReq(netReq));
	sce_net_peer peer (.clk(clk), .reset(reset), .req(netReq), .inject(inject), .delay(delay),
		.fail(fail), .evt(netEvent));

	always #4 clk = ~clk;

	always @(negedge clk) begin
		if (netReq.arpReq) nArp++;
		if (netReq.finReq) nFin++;
		if (netReq.keepReq) begin
			nKeep++;
			lastTo = netReq.sendTo;
		end
		if (netReq.rxRelease) begin
			nRel++;
			lastRx = netReq.rxReadPtr;
		end
		if (netReq.sendReq) begin
			nSend++;
			arpAtSend = nArp;
			{lastFrom, lastTo, lastSkip, lastHw} = {netReq.sendFrom, netReq.sendTo,
				netReq.skipResolve, netReq.peerHwAddr};
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nErrors++;
			conclude();
		end
	end

	task automatic conclude();
		if (nErrors == 0 && nChecks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic cmp(input string what, input logic [15:0] seen, input int exp);
		nChecks++;
		if (seen !== exp[15:0]) begin
			nErrors++;
			$display("wrong value %s expected %h seen %h", what, exp[15:0], seen);
		end
	endtask

	function automatic void nxt();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		{regAddr, regWdata, regWrite} = {a, d, 1'b1};
		@(negedge clk);
		regWrite = 0;
	endtask

	task automatic chk(input string what, input logic [7:0] a, input int exp);
		@(negedge clk);
		{regAddr, regRead} = {a, 1'b1};
		@(negedge clk);
		regRead = 0;
		cmp("read answer", 16'(regRvalid), 1);
		cmp(what, 16'(regRdata), exp);
	endtask

	task automatic check();
		chk("state", OFS_STATE, expState);
		chk("flags", OFS_FLAGS, expFlags);
	endtask

	task automatic hit(input int b);
		expFlags |= expMask[b] << b;
	endtask

	task automatic clr(input int b);
		wr(OFS_FLAGS, 8'(1 << b));
		expFlags &= ~(1 << b);
	endtask

	task automatic ev(input logic [9:0] v);
		@(negedge clk);
		inject = v;
		@(negedge clk);
		inject = '0;
	endtask

	task automatic run(input logic [7:0] code);
		wr(OFS_CMD, code);
		repeat (24) @(negedge clk);
	endtask

	task automatic conn();
		ev(10'h200);
		if (expState != 'h17) hit(0);
		expState = 'h17;
	endtask

	initial begin
		logic [47:0] hw;
		logic [15:0] tw;
		repeat (6) @(posedge clk);
		@(negedge clk);
		reset = 0;
		check();
		chk("mask", OFS_MASK, 255);
		chk("unmapped", 8'h3F, 0);
		wr(OFS_MODE, 8'h01);
		conn();
		check();
		wr(OFS_FLAGS, 8'hE1);
		expFlags = 0;
		conn();
		ev(10'h020);
		hit(2);
		ev(10'h120);
		hit(1);
		expState = 'h1C;
		check();
		wr(OFS_FLAGS, 8'h04);
		expFlags &= ~4;
		check();
		wr(OFS_MASK, 8'hFB);
		expMask = 'hFB;
		ev(10'h020);
		check();
		wr(OFS_MASK, 8'hFF);
		expMask = 255;
		delay = 4'hF;
		clr(1);
		wr(OFS_CMD, 8'h08);
		repeat (2) @(negedge clk);
		chk("state", OFS_STATE, 'h1D);
		repeat (24) @(negedge clk);
		expState = 0;
		hit(1);
		check();
		conn();
		fail = 1;
		wr(OFS_CMD, 8'h08);
		repeat (2) @(negedge clk);
		chk("state", OFS_STATE, 'h18);
		repeat (24) @(negedge clk);
		expState = 0;
		hit(3);
		check();
		cmp("fin count", 16'(nFin), 2);
		conn();
		{fail, delay} = {1'b0, 4'h3};
		nxt();
		txReadPtr = rnd[15:0];
		nxt();
		tw = rnd[15:0];
		wr(OFS_TXWR_H, tw[15:8]);
		wr(OFS_TXWR_L, tw[7:0]);
		run(CMD_SEND);
		cmp("arp before send", 16'(arpAtSend), 1);
		cmp("send from", lastFrom, txReadPtr);
		cmp("send to", lastTo, tw);
		hit(4);
		check();
		clr(3);
		fail = 1;
		run(CMD_SEND);
		hit(3);
		cmp("send count", 16'(nSend), 1);
		check();
		fail = 0;
		run(CMD_SEND_NOAR);
		cmp("send count", 16'(nSend), 1);
		chk("command", OFS_CMD, 0);
		wr(OFS_MODE, 8'h02);
		for (int i = 0; i < 6; i++) begin
			nxt();
			hw = {hw[39:0], rnd[7:0]};
			wr(8'(OFS_HWADDR_LO + i), rnd[7:0]);
		end
		clr(4);
		run(CMD_SEND_NOAR);
		run(CMD_KEEPALIVE);
		run(8'h08);
		hit(4);
		cmp("arp count", 16'(nArp), 2);
		cmp("skip", 16'(lastSkip), 1);
		cmp("hw addr hi", lastHw[47:32], hw[47:32]);
		cmp("hw addr mid", lastHw[31:16], hw[31:16]);
		cmp("hw addr lo", lastHw[15:0], hw[15:0]);
		cmp("probe count", 16'(nKeep), 0);
		cmp("fin count", 16'(nFin), 2);
		check();
		wr(OFS_MODE, 8'h01);
		run(CMD_KEEPALIVE);
		cmp("probe end", lastTo, 32'(txReadPtr) + 1);
		check();
		clr(3);
		fail = 1;
		run(CMD_KEEPALIVE);
		expState = 0;
		hit(3);
		check();
		conn();
		run(CMD_CLOSE);
		expState = 0;
		cmp("fin count", 16'(nFin), 2);
		check();
		conn();
		ev(10'h040);
		expState = 0;
		check();
		nxt();
		wr(OFS_RXRD_H, rnd[15:8]);
		wr(OFS_RXRD_L, rnd[7:0]);
		run(8'h40);
		cmp("release count", 16'(nRel), 1);
		cmp("release ptr", lastRx, rnd[15:0]);
		conclude();
	end
endmodule // sce_socket_cmd_tb
`default_nettype wire
